// [hw/tsi_pkg.sv]
// How it works
// - Linear sample spans two consecutive slots from the programmed slot; companded uses one.
// - Linear coding and signaling apply only in PCM mode, never in GCI mode.
// - Signaling mode puts a signaling byte in the slot after each companded byte.
// - Frame sync marks transmit slot 0; transmit slots count from it.
// - Transmit slot number is a 7-bit field, up to 128 slots.
// - Any bit clock from 128 kHz to 8.192 MHz works, 2 to 128 slots.
// - A 3-bit transmit clock slot delays the transmit slot by 0 to 7 bits.
// - A partial slot at frame end under clock-slot offset drives tristate control.
// - Transmit bytes go out most significant bit first.
// - Transmit goes to port A, B or both, with matching low tristate control.
// - An option picks rising or falling bit clock edge for transmit outputs.
// - Host reads the last transmit data word with the read command.
// - GCI upstream channel carries voice 1, voice 2, monitor, then signaling/control.
// - GCI frame sync marks channel 0; two select levels pick the channels.
// - GCI upstream runs at a fixed 2.048 MHz bit rate.
// - Companded receive bytes go to expansion; linear words bypass it.
// - Frame sync marks receive slot 0; receive slots use their own 7-bit field.
// - A separate 3-bit receive clock slot delays the receive slot by 0 to 7.
// - An option selects receive port A or port B.
// - After reset channels use slots 0 to 3, clock slots zero, falling edge.
// - Signaling byte MSB follows the data byte LSB with no gap.
// - GCI downstream is not received; receive slots open only in PCM mode.
package tsi_pkg;
  localparam int unsigned TSI_CHANNELS = 4;
  localparam int unsigned TSI_SLOT_W = 7;
  localparam int unsigned TSI_CSLOT_W = 3;
  localparam int unsigned TSI_BITCNT_W = 10;
  localparam int unsigned TSI_GCI_BYTES = 4;
  localparam logic [1:0] TSI_CMD_W = 2'h2;
  localparam logic [TSI_CSLOT_W-1:0] TSI_CSLOT_RST = 3'h0;
  localparam logic TSI_EDGE_RISE_RST = 1'b0;
  localparam logic [1:0] TSI_PORT_RST = 2'h1;
  localparam logic TSI_RXB_RST = 1'b0;
  localparam logic [7:0] TSI_READ_TX_CMD = 8'hcd;
  localparam logic [7:0] TSI_CMD_TX_SLOT = 8'h40;
  localparam logic [7:0] TSI_CMD_RX_SLOT = 8'h41;
  localparam logic [7:0] TSI_CMD_CONFIG = 8'h42;
  localparam logic [7:0] TSI_CMD_STATUS = 8'h43;
  localparam int unsigned TSI_CFG_LINEAR = 0;
  localparam int unsigned TSI_CFG_SIGNAL = 1;
  localparam int unsigned TSI_CFG_GCI = 2;
  localparam int unsigned TSI_CFG_RISE = 3;
  localparam int unsigned TSI_CFG_PORTA = 4;
  localparam int unsigned TSI_CFG_PORTB = 5;
  localparam int unsigned TSI_CFG_RXB = 6;
  localparam int unsigned TSI_GCI_BITS = 32;
  localparam real TSI_GCI_RATE_MHZ = 2.048;
  typedef enum logic [1:0] {
    TSI_IDLE_STATE = 2'b00,
    TSI_BYTE0_STATE = 2'b01,
    TSI_BYTE1_STATE = 2'b10
  } tsi_phase_type;
endpackage

// [hw/tsi_core.sv]
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tsi_core #(
  parameter int unsigned CHANNELS = tsi_pkg::TSI_CHANNELS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic bit_clk,
  input wire logic frame_sync_pulse,
  input wire logic receive_port_a,
  input wire logic receive_port_b,
  input wire logic channel_select_low,
  input wire logic channel_select_high,
  input wire logic [1:0] tx_chan,
  input wire logic [15:0] tx_sample,
  input wire logic [7:0] tx_signal,
  input wire logic [7:0] tx_monitor,
  input wire logic [7:0] tx_sc,
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_write,
  input wire logic cmd_read,
  output logic [15:0] cmd_rdata,
  output logic transmit_port_a,
  output logic transmit_port_a_oe,
  output logic transmit_port_b,
  output logic transmit_port_b_oe,
  output logic tristate_ctl_a_n,
  output logic tristate_ctl_b_n,
  output logic rx_valid,
  output logic rx_linear,
  output logic [1:0] rx_chan,
  output logic [15:0] rx_word
);
  import tsi_pkg::*;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  logic [CHANNELS*TSI_SLOT_W-1:0] tx_slot_q;
  logic [CHANNELS*TSI_SLOT_W-1:0] rx_slot_q;
  logic [TSI_CSLOT_W-1:0] tx_cslot_q;
  logic [TSI_CSLOT_W-1:0] rx_cslot_q;
  logic [7:0] cfg_q;
  logic [15:0] last_tx_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        tx_slot_q[i*TSI_SLOT_W +: TSI_SLOT_W] <= TSI_SLOT_W'(i);
        rx_slot_q[i*TSI_SLOT_W +: TSI_SLOT_W] <= TSI_SLOT_W'(i);
      end
      tx_cslot_q <= TSI_CSLOT_RST;
      rx_cslot_q <= TSI_CSLOT_RST;
      cfg_q <= {1'b0, TSI_RXB_RST, TSI_PORT_RST[1], TSI_PORT_RST[0], TSI_EDGE_RISE_RST, 3'h0};
    end else if (cmd_write) begin
      case (cmd_addr)
        TSI_CMD_TX_SLOT: begin
          tx_slot_q[cmd_wdata[9:8]*TSI_SLOT_W +: TSI_SLOT_W] <= cmd_wdata[6:0];
          tx_cslot_q <= cmd_wdata[14:12];
        end
        TSI_CMD_RX_SLOT: begin
          rx_slot_q[cmd_wdata[9:8]*TSI_SLOT_W +: TSI_SLOT_W] <= cmd_wdata[6:0];
          rx_cslot_q <= cmd_wdata[14:12];
        end
        TSI_CMD_CONFIG: begin
          cfg_q <= cmd_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  logic gci_mode;
  logic linear_on;
  logic signal_on;
  assign gci_mode = cfg_q[TSI_CFG_GCI];
  assign linear_on = cfg_q[TSI_CFG_LINEAR] & ~gci_mode;
  assign signal_on = cfg_q[TSI_CFG_SIGNAL] & ~gci_mode & ~linear_on;

  // ----------------------------------------------------------------
  // Bit clock edges and frame counters
  // ----------------------------------------------------------------
  logic bclk_q;
  logic fs_q;
  logic [TSI_BITCNT_W-1:0] bit_cnt_q;
  logic [TSI_BITCNT_W-1:0] frame_len_q;
  logic rise;
  logic fall;
  assign rise = bit_clk & ~bclk_q;
  assign fall = ~bit_clk & bclk_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bclk_q <= 1'b0;
      fs_q <= 1'b0;
      bit_cnt_q <= '0;
      frame_len_q <= '1;
    end else begin
      bclk_q <= bit_clk;
      if (fall) begin
        fs_q <= frame_sync_pulse;
        if (frame_sync_pulse && !fs_q) begin
          bit_cnt_q <= '0;
          frame_len_q <= bit_cnt_q;
        end else begin
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  logic [CHANNELS*16-1:0] tx_word_q;
  logic [CHANNELS*32-1:0] gci_word_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_word_q <= '0;
      gci_word_q <= '0;
      last_tx_q <= '0;
    end else begin
      // In signaling mode the signaling byte rides directly behind the companded byte.
      tx_word_q[tx_chan*16 +: 16] <= linear_on ? tx_sample
                                   : {tx_sample[7:0], tx_signal};
      // The second voice byte of a GCI pair is read from the odd neighbour at send time.
      gci_word_q[tx_chan*32 +: 32] <= {tx_sample[7:0], 8'h00,
                                      tx_monitor, tx_sc};
      last_tx_q <= tx_sample;
    end
  end

  // Position inside the frame after the clock-slot delay, shared by every channel.
  logic [TSI_BITCNT_W-1:0] tx_pos;
  logic [TSI_BITCNT_W-1:0] tail_start;
  assign tx_pos = bit_cnt_q - TSI_BITCNT_W'(tx_cslot_q);
  assign tail_start = {frame_len_q[TSI_BITCNT_W-1:3], 3'h0};

  logic tx_act;
  logic tx_bit;
  always_comb begin
    logic [TSI_BITCNT_W-1:0] base;
    logic [TSI_BITCNT_W-1:0] off;
    logic [1:0] gch;
    base = '0;
    off = '0;
    gch = {channel_select_high, channel_select_low};
    tx_act = 1'b0;
    tx_bit = 1'b0;
    if (gci_mode) begin
      for (int c = 0; c < CHANNELS; c++) begin
        // Channel pairs share one GCI slot of 32 bits at the 2.048 MHz rate.
        base = TSI_BITCNT_W'(({gch, 1'b0} + 3'(c >> 1)) * TSI_GCI_BITS);
        off = bit_cnt_q - base;
        if (bit_cnt_q >= base && off < TSI_BITCNT_W'(TSI_GCI_BITS) && c[0] == 1'b0) begin
          tx_act = 1'b1;
          if (off[4:3] == 2'h1) begin
            tx_bit = gci_word_q[(c | 1)*32 + 31 - int'(off[2:0])];
          end else begin
            tx_bit = gci_word_q[c*32 + 31 - int'(off[4:0])];
          end
        end
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        base = {tx_slot_q[c*TSI_SLOT_W +: TSI_SLOT_W], 3'h0};
        off = tx_pos - base;
        if (bit_cnt_q >= TSI_BITCNT_W'(tx_cslot_q) && tx_pos >= base
            && off < ((linear_on || signal_on) ? TSI_BITCNT_W'(16) : TSI_BITCNT_W'(8))) begin
          tx_act = 1'b1;
          tx_bit = (linear_on || signal_on) ? tx_word_q[c*16 + 15 - int'(off[3:0])]
                 : tx_word_q[c*16 + 15 - int'(off[2:0])];
        end
      end
      // Data bit 0 unless a slot covers it, with control asserted in the fractional tail once shifted past it.
      if (bit_cnt_q >= tail_start && frame_len_q[2:0] != 3'h7
          && tx_cslot_q > frame_len_q[2:0] + 3'h1) begin
        tx_act = 1'b1;
      end
    end
  end

  logic out_edge;
  logic out_edge_q;
  assign out_edge = cfg_q[TSI_CFG_RISE] ? rise : fall;

  // The outputs wait one clock so that they show the bit of the count that the edge advanced.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_edge_q <= 1'b0;
    end else begin
      out_edge_q <= out_edge;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      transmit_port_a <= 1'b0;
      transmit_port_b <= 1'b0;
      transmit_port_a_oe <= 1'b0;
      transmit_port_b_oe <= 1'b0;
      tristate_ctl_a_n <= 1'b1;
      tristate_ctl_b_n <= 1'b1;
    end else if (out_edge_q) begin
      transmit_port_a <= tx_bit;
      transmit_port_b <= tx_bit;
      // GCI upstream always leaves on port A.
      transmit_port_a_oe <= tx_act & (cfg_q[TSI_CFG_PORTA] | gci_mode);
      transmit_port_b_oe <= tx_act & cfg_q[TSI_CFG_PORTB] & ~gci_mode;
      tristate_ctl_a_n <= ~(tx_act & (cfg_q[TSI_CFG_PORTA] | gci_mode));
      tristate_ctl_b_n <= ~(tx_act & cfg_q[TSI_CFG_PORTB] & ~gci_mode);
    end
  end

  // ----------------------------------------------------------------
  // Receive
  // ----------------------------------------------------------------
  logic [15:0] rx_sh_q;
  logic [4:0] rx_cnt_q;
  logic [1:0] rx_ch_q;
  logic rx_busy_q;
  logic rx_in;
  logic [TSI_BITCNT_W-1:0] rx_pos;
  assign rx_in = (cfg_q[TSI_CFG_RXB] & ~gci_mode) ? receive_port_b : receive_port_a;
  assign rx_pos = bit_cnt_q - TSI_BITCNT_W'(rx_cslot_q);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
      rx_ch_q <= '0;
      rx_busy_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_linear <= 1'b0;
      rx_chan <= '0;
      rx_word <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (rise) begin
        if (!rx_busy_q) begin
          for (int c = 0; c < CHANNELS; c++) begin
            if (rx_pos == {rx_slot_q[c*TSI_SLOT_W +: TSI_SLOT_W], 3'h0}
                && bit_cnt_q >= TSI_BITCNT_W'(rx_cslot_q) && !gci_mode) begin
              rx_busy_q <= 1'b1;
              rx_ch_q <= 2'(c);
              rx_cnt_q <= 5'h1;
              rx_sh_q <= {15'h0, rx_in};
            end
          end
        end else begin
          rx_sh_q <= {rx_sh_q[14:0], rx_in};
          rx_cnt_q <= rx_cnt_q + 5'h1;
          if (rx_cnt_q == (linear_on ? 5'hf : 5'h7)) begin
            rx_busy_q <= 1'b0;
            rx_valid <= 1'b1;
            rx_linear <= linear_on;
            rx_chan <= rx_ch_q;
            rx_word <= linear_on ? {rx_sh_q[14:0], rx_in}
                     : {8'h0, rx_sh_q[6:0], rx_in};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_rdata <= '0;
    end else if (cmd_read) begin
      case (cmd_addr)
        TSI_READ_TX_CMD: cmd_rdata <= last_tx_q;
        TSI_CMD_CONFIG: cmd_rdata <= {8'h0, cfg_q};
        TSI_CMD_STATUS: cmd_rdata <= {6'h0, frame_len_q};
        default: cmd_rdata <= 16'h0;
      endcase
    end else begin
      cmd_rdata <= 16'h0;
    end
  end
endmodule // tsi_core

// [verification/tsi_checker.sv]
`timescale 1ns/1ps
module tsi_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic bit_clk,
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_rdata,
  input wire logic transmit_port_a_oe,
  input wire logic transmit_port_b_oe,
  input wire logic tristate_ctl_a_n,
  input wire logic tristate_ctl_b_n,
  input wire logic rx_valid,
  input wire logic [15:0] rx_word
);
  import tsi_pkg::*;
  // ----
  // Clocks since the last highway clock transition.
  // ----
  logic bclk_q;
  logic [3:0] since_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bclk_q <= 1'b0;
      since_q <= 4'hf;
    end else begin
      bclk_q <= bit_clk;
      since_q <= (bit_clk != bclk_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_cfg_wr_rd;
    cmd_write && cmd_addr == TSI_CMD_CONFIG ##1 cmd_read && cmd_addr == TSI_CMD_CONFIG;
  endsequence
  property p_cfg_back;
    s_cfg_wr_rd |=> cmd_rdata[6:0] == $past(cmd_wdata[6:0], 2);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config read back differs");
  property p_oe_a;
    transmit_port_a_oe == !tristate_ctl_a_n;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("port a control mismatch");
  property p_oe_b;
    transmit_port_b_oe == !tristate_ctl_b_n;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port b control mismatch");
  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe too long");
  property p_rx_hold;
    $changed(rx_word) |-> rx_valid;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive word moved");
  property p_rd_idle;
    !cmd_read |=> cmd_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rd_unmapped;
    cmd_read && cmd_addr == 8'h00 |=> cmd_rdata == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_edge_a;
    $changed(transmit_port_a_oe) |-> since_q <= 4'h6;
  endproperty
  a_edge_a: assert property (p_edge_a) else $error("port a moved off clock edge");
endmodule // tsi_checker

// [verification/tsi_highway.sv]
`timescale 1ns/1ps
module tsi_highway #(
  parameter int HALF = 13,
  parameter int BITS = 128
) (
  input wire logic clock,
  output logic bit_clk,
  output logic frame_sync_pulse,
  output logic receive_port_a,
  output logic receive_port_b,
  input wire logic transmit_port_a,
  input wire logic transmit_port_a_oe,
  input wire logic transmit_port_b,
  input wire logic transmit_port_b_oe,
  output logic [BITS-1:0] cap_a,
  output logic [BITS-1:0] cap_b,
  output logic [BITS-1:0] en_a,
  output logic [BITS-1:0] en_b,
  output logic frame_done
);
  // ----
  // Free-running bit clock; a frame of whole bytes leaves no partial slot.
  // ----
  int n = BITS - 1;
  int t = 0;
  initial begin
    bit_clk = 1'b0;
    frame_sync_pulse = 1'b0;
    receive_port_a = 1'b0;
    receive_port_b = 1'b1;
    frame_done = 1'b0;
  end
  always @(posedge clock) begin
    frame_done <= 1'b0;
    t = t + 1;
    if (t == HALF) begin
      t = 0;
      bit_clk <= ~bit_clk;
      if (bit_clk) begin
        n = (n == BITS - 1) ? 0 : n + 1;
        receive_port_a <= n[0] ^ n[3];
        receive_port_b <= ~(n[0] ^ n[3]);
      end else begin
        cap_a[n] <= transmit_port_a;
        cap_b[n] <= transmit_port_b;
        en_a[n] <= transmit_port_a_oe;
        en_b[n] <= transmit_port_b_oe;
        frame_sync_pulse <= (n == BITS - 1);
        frame_done <= (n == BITS - 1);
      end
    end
  end
endmodule // tsi_highway

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import tsi_pkg::*;
  localparam int BITS = 128;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sel = 1'b0;
  logic [1:0] tx_chan = 2'h0;
  logic [15:0] tx_sample = 16'h0000;
  logic [7:0] tx_signal = 8'h00;
  logic [7:0] cmd_addr = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_write = 1'b0;
  logic cmd_read = 1'b0;
  logic bclk, fsp, rxa, rxb, fdone, txa, txa_oe, txb, txb_oe, rx_valid, rx_linear;
  logic [1:0] rx_chan;
  logic [15:0] cmd_rdata, rx_word;
  logic [BITS-1:0] cap_a, cap_b, en_a, en_b;
  logic [15:0] smp [4] = '{16'h81a5, 16'h42c3, 16'h2417, 16'h18e9};
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int sl [4];
  always #2.5 clock = ~clock;
  tsi_core i_dut (.clock(clock), .arst_n(arst_n), .bit_clk(bclk), .frame_sync_pulse(fsp),
    .receive_port_a(rxa), .receive_port_b(rxb), .channel_select_low(sel),
    .channel_select_high(sel), .tx_chan(tx_chan), .tx_sample(tx_sample), .tx_signal(tx_signal),
    .tx_monitor(tx_signal), .tx_sc(tx_signal), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .transmit_port_a(txa),
    .transmit_port_a_oe(txa_oe), .transmit_port_b(txb), .transmit_port_b_oe(txb_oe),
    .tristate_ctl_a_n(), .tristate_ctl_b_n(), .rx_valid(rx_valid), .rx_linear(rx_linear),
    .rx_chan(rx_chan), .rx_word(rx_word));
  tsi_highway #(.HALF(13), .BITS(BITS)) i_hwy (.clock(clock), .bit_clk(bclk),
    .frame_sync_pulse(fsp), .receive_port_a(rxa), .receive_port_b(rxb), .transmit_port_a(txa),
    .transmit_port_a_oe(txa_oe), .transmit_port_b(txb), .transmit_port_b_oe(txb_oe),
    .cap_a(cap_a), .cap_b(cap_b), .en_a(en_a), .en_b(en_b), .frame_done(fdone));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_write <= 1'b1;
    @(posedge clock);
    cmd_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    cmd_addr <= a;
    cmd_read <= 1'b1;
    @(posedge clock);
    cmd_read <= 1'b0;
    @(posedge clock);
    chk(cmd_rdata, exp);
  endtask
  task automatic load;
    for (int k = 0; k < 4; k++) begin
      tx_chan <= 2'(k);
      tx_sample <= smp[k];
      tx_signal <= ~smp[k][7:0];
      @(posedge clock);
    end
  endtask
  task automatic frames(input int k);
    repeat (k) @(posedge clock iff fdone);
  endtask
  task automatic rx_chk(input logic [15:0] exp, input logic lin);
    frames(1);
    @(posedge clock iff (rx_valid === 1'b1 && rx_chan === 2'h0));
    chk(lin ? rx_word : {8'h00, rx_word[7:0]}, exp);
    chk(rx_linear, lin);
  endtask
  // ----
  // One captured frame against the slot table.
  // ----
  task automatic chk_frame(input int cs, input int w, input bit gci, input bit lin,
    input bit pa, input bit pb);
    logic e, d, dk;
    int b, i;
    logic [15:0] wd;
    frames(2);
    for (int n = 0; n < BITS; n++) begin
      e = 1'b0;
      dk = 1'b0;
      d = 1'b0;
      for (int k = 0; k < 4; k++) begin
        b = gci ? (k / 2) * 32 : sl[k] * 8 + cs;
        i = n - b - (gci ? (k % 2) * 8 : 0);
        wd = (gci || w == 8) ? {smp[k][7:0], 8'h00} : lin ? smp[k] : {smp[k][7:0], ~smp[k][7:0]};
        if (n >= b && n < b + (gci ? 32 : w)) e = 1'b1;
        if (i >= 0 && i < (gci ? 8 : w)) begin
          dk = 1'b1;
          d = wd[15-i];
        end
      end
      chk(en_a[n], pa & e);
      chk(en_b[n], pb & e);
      if (dk && pa) chk(cap_a[n], d);
      if (dk && pb) chk(cap_b[n], d);
    end
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    load;
    rd(TSI_CMD_CONFIG, 16'h0010);
    wr(8'h00, 16'hffff);
    rd(8'h00, 16'h0000);
    rd(TSI_CMD_CONFIG, 16'h0010);
    sl = '{0, 1, 2, 3};
    chk_frame(0, 8, 0, 0, 1, 0);
    wr(TSI_CMD_TX_SLOT, 16'h300e);
    sl[0] = 14;
    chk_frame(3, 8, 0, 0, 1, 0);
    sl = '{14, 2, 4, 6};
    for (int k = 1; k < 4; k++) begin
      wr(TSI_CMD_TX_SLOT, 16'(k * 256 + sl[k]));
      @(posedge clock);
    end
    wr(TSI_CMD_CONFIG, 16'h0031);
    rd(TSI_CMD_CONFIG, 16'h0031);
    load;
    chk_frame(0, 16, 0, 1, 1, 1);
    wr(TSI_CMD_CONFIG, 16'h0022);
    load;
    chk_frame(0, 16, 0, 0, 0, 1);
    wr(TSI_CMD_CONFIG, 16'h0010);
    rx_chk(16'h0055, 1'b0);
    wr(TSI_CMD_CONFIG, 16'h0050);
    rx_chk(16'h00aa, 1'b0);
    wr(TSI_CMD_RX_SLOT, 16'h0008);
    @(posedge clock);
    wr(TSI_CMD_CONFIG, 16'h0011);
    rx_chk(16'h55aa, 1'b1);
    wr(TSI_CMD_CONFIG, 16'h0015);
    chk_frame(0, 8, 1, 0, 1, 0);
    close_out;
  end
endmodule // tb_top
bind tsi_core tsi_checker i_chk (.clock(clock), .arst_n(arst_n), .bit_clk(bit_clk),
  .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read),
  .cmd_rdata(cmd_rdata), .transmit_port_a_oe(transmit_port_a_oe),
  .transmit_port_b_oe(transmit_port_b_oe), .tristate_ctl_a_n(tristate_ctl_a_n),
  .tristate_ctl_b_n(tristate_ctl_b_n), .rx_valid(rx_valid), .rx_word(rx_word));
